// >>> srr_defines.vh
// Constants for the status reporting register block.
// Assumes inclusion by bare name from design files only.
`ifndef SRR_DEFINES_VH
`define SRR_DEFINES_VH

`define SRR_W            15
`define SRR_ALL_ONES     15'h7FFF
`define SRR_ALL_ZERO     15'h0000
`define SRR_MASK_RST     15'h0000
`define SRR_RISE_RST     15'h7FFF
`define SRR_FALL_RST     15'h0000

// Register selects on the command port
`define SRR_SEL_W        4
`define SRR_SEL_RUN_LVL  4'h0
`define SRR_SEL_RUN_EVT  4'h1
`define SRR_SEL_RUN_MSK  4'h2
`define SRR_SEL_RUN_RISE 4'h3
`define SRR_SEL_RUN_FALL 4'h4
`define SRR_SEL_HLT_LVL  4'h5
`define SRR_SEL_HLT_EVT  4'h6
`define SRR_SEL_HLT_MSK  4'h7
`define SRR_SEL_HLT_RISE 4'h8
`define SRR_SEL_HLT_FALL 4'h9

// Level bit positions
`define SRR_RUN_SWEEP_BIT    3
`define SRR_RUN_SELFTEST_BIT 9
`define SRR_HLT_UNLEVEL_BIT  3
`define SRR_HLT_LOCKERR_BIT  5
`define SRR_HLT_STFAIL_BIT   9

// Error queue
`define SRR_Q_DEPTH      10
`define SRR_Q_AW         4
`define SRR_Q_LAST       4'h9
`define SRR_Q_CNT_W      4
`define SRR_Q_FULL_CNT   4'hA
`define SRR_CODE_W       16
`define SRR_DESC_W       8
`define SRR_ENTRY_W      24
`define SRR_OVF_CODE     16'hFEA2
`define SRR_OVF_DESC     8'h01
`define SRR_NONE_CODE    16'h0000
`define SRR_NONE_DESC    8'h00
`define SRR_SUM_ERRQ_BIT 2

`endif

// >>> srr_qmem.v
// Small storage for the error queue entries.
// Assumes a single writer and a single reader per cycle.
`timescale 1ns/1ns
`default_nettype none
`include "srr_defines.vh"

module srr_qmem (
   // Clock
   input  wire                      i_clk_sys,
   // Write side
   input  wire                      i_we,
   input  wire [`SRR_Q_AW-1:0]      i_waddr,
   input  wire [`SRR_ENTRY_W-1:0]   i_wdata,
   // Read side
   input  wire [`SRR_Q_AW-1:0]      i_raddr,
   output reg  [`SRR_ENTRY_W-1:0]   o_rdata
);

   reg [`SRR_ENTRY_W-1:0] mem [0:`SRR_Q_DEPTH-1];

   always @(posedge i_clk_sys) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end

endmodule
`default_nettype wire

// >>> srr_group.v
// One status group: level, transition filters, latched events, mask.
// Assumes level bits are synchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
`include "srr_defines.vh"

module srr_group (
   // Clock and reset
   input  wire                i_clk_sys,
   input  wire                i_srst,
   // Condition inputs
   input  wire [`SRR_W-1:0]   i_level,
   // Register writes
   input  wire                i_preset,
   input  wire                i_wr_mask,
   input  wire                i_wr_rise,
   input  wire                i_wr_fall,
   input  wire [`SRR_W-1:0]   i_wdata,
   // Read of latched events, clears it
   input  wire                i_rd_event,
   // Register contents
   output wire [`SRR_W-1:0]   o_level,
   output reg  [`SRR_W-1:0]   o_event,
   output reg  [`SRR_W-1:0]   o_mask,
   output reg  [`SRR_W-1:0]   o_rise,
   output reg  [`SRR_W-1:0]   o_fall,
   output wire                o_summary
);

   reg  [`SRR_W-1:0] level_r;
   wire [`SRR_W-1:0] hits;

   assign o_level = level_r;
   assign hits = ((i_level & ~level_r) & o_rise)
               | ((~i_level & level_r) & o_fall);
   assign o_summary = |(o_event & o_mask);

   always @(posedge i_clk_sys) begin
      if (i_srst) begin
         level_r <= `SRR_ALL_ZERO;
         o_event <= `SRR_ALL_ZERO;
         o_mask  <= `SRR_MASK_RST;
         o_rise  <= `SRR_RISE_RST;
         o_fall  <= `SRR_FALL_RST;
      end else begin
         level_r <= i_level;
         // New edges win over the clear of the read
         o_event <= (i_rd_event ? `SRR_ALL_ZERO : o_event) | hits;
         if (i_preset) begin
            o_mask <= `SRR_ALL_ZERO;
            o_rise <= `SRR_ALL_ONES;
            o_fall <= `SRR_ALL_ZERO;
         end else begin
            if (i_wr_mask) begin
               o_mask <= i_wdata;
            end
            if (i_wr_rise) begin
               o_rise <= i_wdata;
            end
            if (i_wr_fall) begin
               o_fall <= i_wdata;
            end
         end
      end
   end

endmodule
`default_nettype wire

// >>> srr_top.v
// Overview of operation
// - Reading a latched event register returns it, then clears it.
// - Reading a live level register returns it and leaves it unchanged.
// - Enable masks hold 0..32767, reset to 0, writable and readable.
// - False-to-true level edge with rise filter bit sets event bit.
// - True-to-false level edge with fall filter bit sets event bit.
// - Run-state bit 3 is true while a sweep is in progress.
// - Run-state bit 9 is true while self-test runs.
// - Health bit 9 becomes true when self-test has failed.
// - Health bit 3 is true while output is unleveled.
// - Health bit weight 32 reports lock error or unlocked output.
// - Preset clears masks, sets rise filters to ones, clears fall filters.
// - Errors append to a FIFO queue of at most ten code/description entries.
// - Queue read returns the oldest entry and removes it.
// - Summary bit 2 is one whenever the queue is not empty.
// - Reading an empty queue returns error code zero.
// - Error into full queue without a same-cycle queue read overwrites newest entry with -350, no growth.
//
// Top of the status reporting block: two groups and the error queue.
// Assumes a command decoder issuing one-cycle read and write strobes.
`timescale 1ns/1ns
`default_nettype none
`include "srr_defines.vh"

module srr_top (
   // Clock and reset
   input  wire                      i_clk_sys,
   input  wire                      i_srst,
   // Instrument conditions
   input  wire                      i_sweeping,
   input  wire                      i_selftest_busy,
   input  wire                      i_selftest_failed,
   input  wire                      i_unleveled,
   input  wire                      i_lock_error,
   input  wire [`SRR_W-1:0]         i_run_other,
   input  wire [`SRR_W-1:0]         i_health_other,
   // Register commands
   input  wire                      i_reg_rd,
   input  wire                      i_reg_wr,
   input  wire [`SRR_SEL_W-1:0]     i_reg_sel,
   input  wire [`SRR_W-1:0]         i_reg_wdata,
   input  wire                      i_preset,
   output reg  [`SRR_W-1:0]         o_reg_rdata,
   output reg                       o_reg_rvalid,
   // Error queue
   input  wire                      i_err_push,
   input  wire [`SRR_CODE_W-1:0]    i_err_code,
   input  wire [`SRR_DESC_W-1:0]    i_err_desc,
   input  wire                      i_err_pop,
   output reg  [`SRR_CODE_W-1:0]    o_err_code,
   output reg  [`SRR_DESC_W-1:0]    o_err_desc,
   output reg                       o_err_valid,
   output wire [`SRR_Q_CNT_W-1:0]   o_err_count,
   // Summaries
   output wire [7:0]                o_summary_byte,
   output wire                      o_run_summary,
   output wire                      o_health_summary
);

   // Wrap an index around the ten slots
   function [`SRR_Q_AW-1:0] srr_inc;
      input [`SRR_Q_AW-1:0] idx;
      begin
         if (idx == `SRR_Q_LAST) begin
            srr_inc = {`SRR_Q_AW{1'b0}};
         end else begin
            srr_inc = idx + 4'h1;
         end
      end
   endfunction

   // Select decode shared by read and write paths
   function sel_is;
      input [`SRR_SEL_W-1:0] sel;
      input [`SRR_SEL_W-1:0] want;
      begin
         sel_is = (sel == want);
      end
   endfunction

   reg  [`SRR_W-1:0] run_lvl_in;
   reg  [`SRR_W-1:0] hlt_lvl_in;

   // Dedicated bits override the generic condition inputs
   always @* begin
      run_lvl_in = i_run_other;
      run_lvl_in[`SRR_RUN_SWEEP_BIT]    = i_sweeping;
      run_lvl_in[`SRR_RUN_SELFTEST_BIT] = i_selftest_busy;
      hlt_lvl_in = i_health_other;
      hlt_lvl_in[`SRR_HLT_STFAIL_BIT]   = i_selftest_failed;
      hlt_lvl_in[`SRR_HLT_UNLEVEL_BIT]  = i_unleveled;
      hlt_lvl_in[`SRR_HLT_LOCKERR_BIT]  = i_lock_error;
   end

   wire [`SRR_W-1:0] run_lvl;
   wire [`SRR_W-1:0] run_evt;
   wire [`SRR_W-1:0] run_msk;
   wire [`SRR_W-1:0] run_rise;
   wire [`SRR_W-1:0] run_fall;
   wire [`SRR_W-1:0] hlt_lvl;
   wire [`SRR_W-1:0] hlt_evt;
   wire [`SRR_W-1:0] hlt_msk;
   wire [`SRR_W-1:0] hlt_rise;
   wire [`SRR_W-1:0] hlt_fall;

   // A read that meets a write is dropped; the write still lands
   wire wr = i_reg_wr;
   wire rd = i_reg_rd & ~i_reg_wr;

   // Per-register write strobes
   wire run_wr_mask;
   wire run_wr_rise;
   wire run_wr_fall;
   wire hlt_wr_mask;
   wire hlt_wr_rise;
   wire hlt_wr_fall;

   // Event reads clear what they return
   wire run_rd_evt;
   wire hlt_rd_evt;

   assign run_wr_mask = wr & sel_is(i_reg_sel, `SRR_SEL_RUN_MSK);
   assign run_wr_rise = wr & sel_is(i_reg_sel, `SRR_SEL_RUN_RISE);
   assign run_wr_fall = wr & sel_is(i_reg_sel, `SRR_SEL_RUN_FALL);
   assign hlt_wr_mask = wr & sel_is(i_reg_sel, `SRR_SEL_HLT_MSK);
   assign hlt_wr_rise = wr & sel_is(i_reg_sel, `SRR_SEL_HLT_RISE);
   assign hlt_wr_fall = wr & sel_is(i_reg_sel, `SRR_SEL_HLT_FALL);
   assign run_rd_evt  = rd & sel_is(i_reg_sel, `SRR_SEL_RUN_EVT);
   assign hlt_rd_evt  = rd & sel_is(i_reg_sel, `SRR_SEL_HLT_EVT);

   srr_group u_run (
      .i_clk_sys  (i_clk_sys),
      .i_srst     (i_srst),
      .i_level    (run_lvl_in),
      .i_preset   (i_preset),
      .i_wr_mask  (run_wr_mask),
      .i_wr_rise  (run_wr_rise),
      .i_wr_fall  (run_wr_fall),
      .i_wdata    (i_reg_wdata),
      .i_rd_event (run_rd_evt),
      .o_level    (run_lvl),
      .o_event    (run_evt),
      .o_mask     (run_msk),
      .o_rise     (run_rise),
      .o_fall     (run_fall),
      .o_summary  (o_run_summary)
   );

   srr_group u_health (
      .i_clk_sys  (i_clk_sys),
      .i_srst     (i_srst),
      .i_level    (hlt_lvl_in),
      .i_preset   (i_preset),
      .i_wr_mask  (hlt_wr_mask),
      .i_wr_rise  (hlt_wr_rise),
      .i_wr_fall  (hlt_wr_fall),
      .i_wdata    (i_reg_wdata),
      .i_rd_event (hlt_rd_evt),
      .o_level    (hlt_lvl),
      .o_event    (hlt_evt),
      .o_mask     (hlt_msk),
      .o_rise     (hlt_rise),
      .o_fall     (hlt_fall),
      .o_summary  (o_health_summary)
   );

   // Register read mux; level reads have no side effect
   reg [`SRR_W-1:0] rd_mux;
   always @* begin
      case (i_reg_sel)
         `SRR_SEL_RUN_LVL:  rd_mux = run_lvl;
         `SRR_SEL_RUN_EVT:  rd_mux = run_evt;
         `SRR_SEL_RUN_MSK:  rd_mux = run_msk;
         `SRR_SEL_RUN_RISE: rd_mux = run_rise;
         `SRR_SEL_RUN_FALL: rd_mux = run_fall;
         `SRR_SEL_HLT_LVL:  rd_mux = hlt_lvl;
         `SRR_SEL_HLT_EVT:  rd_mux = hlt_evt;
         `SRR_SEL_HLT_MSK:  rd_mux = hlt_msk;
         `SRR_SEL_HLT_RISE: rd_mux = hlt_rise;
         `SRR_SEL_HLT_FALL: rd_mux = hlt_fall;
         default:           rd_mux = `SRR_ALL_ZERO;
      endcase
   end

   // Read data holds until the next read
   reg [`SRR_W-1:0] rdata_nxt;
   always @* begin
      rdata_nxt = o_reg_rdata;
      if (rd) begin
         rdata_nxt = rd_mux;
      end
   end

   always @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_reg_rdata  <= `SRR_ALL_ZERO;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rdata  <= rdata_nxt;
         o_reg_rvalid <= rd;
      end
   end

   // Error queue: circular buffer of ten entries
   reg  [`SRR_Q_AW-1:0]    head_r;
   reg  [`SRR_Q_AW-1:0]    tail_r;
   reg  [`SRR_Q_CNT_W-1:0] cnt_r;
   reg                     pop_d_r;
   reg                     pop_empty_r;
   wire [`SRR_ENTRY_W-1:0] q_rdata;

   wire q_empty = (cnt_r == {`SRR_Q_CNT_W{1'b0}});
   wire q_full  = (cnt_r == `SRR_Q_FULL_CNT);
   wire pop_ok  = i_err_pop & ~q_empty;
   // Pop on a full queue frees a slot, so the push goes in normally
   wire push_ovf = i_err_push & q_full & ~pop_ok;
   wire push_ok  = i_err_push & ~push_ovf;

   // Step an index back around the ten slots
   function [`SRR_Q_AW-1:0] srr_dec;
      input [`SRR_Q_AW-1:0] idx;
      begin
         if (idx == {`SRR_Q_AW{1'b0}}) begin
            srr_dec = `SRR_Q_LAST;
         end else begin
            srr_dec = idx - 4'h1;
         end
      end
   endfunction

   // Newest entry sits one slot behind the tail
   wire [`SRR_Q_AW-1:0] newest = srr_dec(tail_r);

   reg                     q_we;
   reg  [`SRR_Q_AW-1:0]    q_waddr;
   reg  [`SRR_ENTRY_W-1:0] q_wdata;

   // Overflow reuses the newest slot, so the oldest entries survive
   always @* begin
      q_we    = 1'b0;
      q_waddr = tail_r;
      q_wdata = {i_err_code, i_err_desc};
      if (push_ovf) begin
         q_we    = 1'b1;
         q_waddr = newest;
         q_wdata = {`SRR_OVF_CODE, `SRR_OVF_DESC};
      end else if (push_ok) begin
         q_we    = 1'b1;
      end
   end

   srr_qmem u_qmem (
      .i_clk_sys (i_clk_sys),
      .i_we      (q_we),
      .i_waddr   (q_waddr),
      .i_wdata   (q_wdata),
      .i_raddr   (head_r),
      .o_rdata   (q_rdata)
   );

   reg  [`SRR_Q_AW-1:0]    head_nxt;
   reg  [`SRR_Q_AW-1:0]    tail_nxt;
   reg  [`SRR_Q_CNT_W-1:0] cnt_nxt;

   // Push and pop together leave the count alone
   always @* begin
      head_nxt = head_r;
      tail_nxt = tail_r;
      cnt_nxt  = cnt_r;
      if (push_ok) begin
         tail_nxt = srr_inc(tail_r);
      end
      if (pop_ok) begin
         head_nxt = srr_inc(head_r);
      end
      if (push_ok & ~pop_ok) begin
         cnt_nxt = cnt_r + 4'h1;
      end else if (pop_ok & ~push_ok) begin
         cnt_nxt = cnt_r - 4'h1;
      end
   end

   always @(posedge i_clk_sys) begin
      if (i_srst) begin
         head_r      <= {`SRR_Q_AW{1'b0}};
         tail_r      <= {`SRR_Q_AW{1'b0}};
         cnt_r       <= {`SRR_Q_CNT_W{1'b0}};
         pop_d_r     <= 1'b0;
         pop_empty_r <= 1'b0;
      end else begin
         head_r      <= head_nxt;
         tail_r      <= tail_nxt;
         cnt_r       <= cnt_nxt;
         pop_d_r     <= i_err_pop;
         pop_empty_r <= i_err_pop & q_empty;
      end
   end

   // Answer two cycles after the pop, from the memory's registered read
   reg  [`SRR_CODE_W-1:0]  code_nxt;
   reg  [`SRR_DESC_W-1:0]  desc_nxt;

   // An empty read answers with the no-error entry
   always @* begin
      code_nxt = o_err_code;
      desc_nxt = o_err_desc;
      if (pop_d_r) begin
         if (pop_empty_r) begin
            code_nxt = `SRR_NONE_CODE;
            desc_nxt = `SRR_NONE_DESC;
         end else begin
            code_nxt = q_rdata[`SRR_ENTRY_W-1:`SRR_DESC_W];
            desc_nxt = q_rdata[`SRR_DESC_W-1:0];
         end
      end
   end

   always @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_err_code  <= `SRR_NONE_CODE;
         o_err_desc  <= `SRR_NONE_DESC;
         o_err_valid <= 1'b0;
      end else begin
         o_err_code  <= code_nxt;
         o_err_desc  <= desc_nxt;
         o_err_valid <= pop_d_r;
      end
   end

   // Only the queue flag lives here; the other summary bits read zero
   reg  [7:0] sum_byte;
   always @* begin
      sum_byte = 8'h00;
      sum_byte[`SRR_SUM_ERRQ_BIT] = ~q_empty;
   end

   assign o_err_count    = cnt_r;
   assign o_summary_byte = sum_byte;

endmodule
`default_nettype wire

// >>> srr_sva.sv
// Checker for the status block top ports.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module srr_sva (
   // Clock, reset
   input wire logic        i_clk_sys,
   input wire logic        i_srst,
   // Requests
   input wire logic        i_reg_rd,
   input wire logic        i_reg_wr,
   input wire logic [3:0]  i_reg_sel,
   input wire logic        i_preset,
   input wire logic        i_err_push,
   input wire logic        i_err_pop,
   // Answers
   input wire logic        o_reg_rvalid,
   input wire logic [14:0] o_reg_rdata,
   input wire logic        o_err_valid,
   input wire logic [15:0] o_err_code,
   input wire logic [3:0]  o_err_count,
   input wire logic [7:0]  o_summary_byte
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   logic rise_ok_r;
   // Run rise filter untouched since reset or preset
   always_ff @(posedge i_clk_sys) begin
      if (i_srst || i_preset)
         rise_ok_r <= 1'b1;
      else if (i_reg_wr && i_reg_sel == 4'h3)
         rise_ok_r <= 1'b0;
   end
   wire rd_only = i_reg_rd && !i_reg_wr;
   wire push_only = i_err_push && !i_err_pop;
   wire pop_only = i_err_pop && !i_err_push;
   chk_rd_answer: assert property (rd_only |=> o_reg_rvalid)
      else $error("read not answered");
   chk_rvalid_cause: assert property (o_reg_rvalid |-> $past(rd_only))
      else $error("answer without read");
   chk_errq_flag: assert property (o_summary_byte == {5'h00, o_err_count != 4'h0, 2'h0})
      else $error("summary bit 2 wrong");
   chk_count_max: assert property (o_err_count <= 4'hA)
      else $error("queue above ten");
   chk_push_grow: assert property (push_only && o_err_count < 4'hA |=> o_err_count == $past(o_err_count) + 4'h1)
      else $error("push did not grow queue");
   chk_full_hold: assert property (push_only && o_err_count == 4'hA |=> o_err_count == 4'hA)
      else $error("full queue changed length");
   chk_pop_shrink: assert property (pop_only && o_err_count != 4'h0 |=> o_err_count == $past(o_err_count) - 4'h1)
      else $error("pop did not remove entry");
   chk_pop_answer: assert property (i_err_pop |-> ##2 o_err_valid)
      else $error("pop not answered");
   chk_empty_zero: assert property (pop_only && o_err_count == 4'h0 |-> ##2 o_err_code == 16'h0000)
      else $error("empty pop code not zero");
   chk_rise_ones: assert property (rd_only && !i_preset && i_reg_sel == 4'h3 && rise_ok_r |=> o_reg_rdata == 15'h7FFF)
      else $error("rise filter not all ones");
   cover property (push_only && o_err_count == 4'hA);
   cover property (pop_only && o_err_count == 4'h0);
   cover property (i_preset ##[1:4] rd_only);
endmodule
`default_nettype wire

// >>> srr_host.sv
// Host model issuing register commands and queue reads.
// Assumes answers arrive within a few clock cycles.
`timescale 1ns/1ns
`default_nettype none
module srr_host (
   // Clock
   input  wire logic        i_clk_sys,
   // Answers
   input  wire logic        i_rvalid,
   input  wire logic [14:0] i_rdata,
   input  wire logic        i_evalid,
   input  wire logic [15:0] i_ecode,
   // Requests
   output logic             o_rd,
   output logic             o_wr,
   output logic [3:0]       o_sel,
   output logic [14:0]      o_wdata,
   output logic             o_preset,
   output logic             o_pop
);
   initial begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_sel = 4'h0;
      o_wdata = 15'h0000;
      o_preset = 1'b0;
      o_pop = 1'b0;
   end
   task automatic step;
      @(posedge i_clk_sys);
      #1;
   endtask
   // Mask and filter writes
   task automatic wr(input logic [3:0] s, input logic [14:0] d);
      step();
      o_sel = s;
      o_wdata = d;
      o_wr = 1'b1;
      step();
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   task automatic rd(input logic [3:0] s, output logic [14:0] d);
      step();
      o_sel = s;
      o_rd = 1'b1;
      step();
      o_rd = 1'b0;
      for (int n = 0; n < 4 && i_rvalid !== 1'b1; n++) step();
      if (i_rvalid !== 1'b1) tb_top.lost();
      d = i_rdata;
   endtask
   task automatic preset;
      step();
      o_preset = 1'b1;
      step();
      o_preset = 1'b0;
   endtask
   // Queue read; waits up to four cycles for the answer code
   task automatic pop(output logic [15:0] e);
      step();
      o_pop = 1'b1;
      step();
      o_pop = 1'b0;
      for (int n = 0; n < 4 && i_evalid !== 1'b1; n++) step();
      if (i_evalid !== 1'b1) tb_top.lost();
      e = i_ecode;
   endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Testbench: host model, condition inputs, error pushes.
// Assumes the block answers within a few cycles.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_top;
   logic        i_clk_sys = 1'b0;
   logic        i_srst = 1'b1;
   logic        i_sweeping = 1'b0, i_selftest_busy = 1'b0, i_selftest_failed = 1'b0;
   logic        i_unleveled = 1'b0, i_lock_error = 1'b0, i_err_push = 1'b0;
   logic [14:0] i_run_other = 15'h0000, i_health_other = 15'h0000, i_reg_wdata, o_reg_rdata, v;
   logic        i_reg_rd, i_reg_wr, i_preset, i_err_pop, o_reg_rvalid, o_err_valid, o_run_summary, o_health_summary;
   logic [3:0]  i_reg_sel, o_err_count;
   logic [15:0] i_err_code = 16'h0000, o_err_code, c;
   logic [7:0]  i_err_desc = 8'h00, o_err_desc, o_summary_byte;
   int          errors = 0, comparisons = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   srr_top dut_u (.i_clk_sys, .i_srst, .i_sweeping, .i_selftest_busy, .i_selftest_failed, .i_unleveled,
      .i_lock_error, .i_run_other, .i_health_other, .i_reg_rd, .i_reg_wr, .i_reg_sel, .i_reg_wdata, .i_preset,
      .o_reg_rdata, .o_reg_rvalid, .i_err_push, .i_err_code, .i_err_desc, .i_err_pop, .o_err_code, .o_err_desc,
      .o_err_valid, .o_err_count, .o_summary_byte, .o_run_summary, .o_health_summary);
   srr_host host_u (.i_clk_sys, .i_rvalid(o_reg_rvalid), .i_rdata(o_reg_rdata), .i_evalid(o_err_valid),
      .i_ecode(o_err_code), .o_rd(i_reg_rd), .o_wr(i_reg_wr), .o_sel(i_reg_sel), .o_wdata(i_reg_wdata),
      .o_preset(i_preset), .o_pop(i_err_pop));
   task automatic stop_test;
      $display("Mismatches %0d, comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic lost;
      errors++;
      stop_test();
   endtask
   task automatic chk_rd(input logic [3:0] s, input logic [14:0] e);
      host_u.rd(s, v);
      `CHK(v, e)
   endtask
   // Masks 0, rise all ones, fall 0
   task automatic defaults;
      for (int n = 2; n < 10; n++)
         if (n != 5 && n != 6) chk_rd(n[3:0], (n == 3 || n == 8) ? 15'h7FFF : 15'h0000);
   endtask
   task automatic push(input logic [15:0] k);
      host_u.step();
      i_err_code = k;
      i_err_desc = k[7:0];
      i_err_push = 1'b1;
      host_u.step();
      i_err_push = 1'b0;
   endtask
   task automatic s_run;
      host_u.wr(4'h2, 15'h7FFF);
      chk_rd(4'h2, 15'h7FFF);
      host_u.wr(4'h2, 15'h0008);
      i_sweeping = 1'b1;
      i_run_other = 15'h7FFF;
      chk_rd(4'h0, 15'h7DFF);
      chk_rd(4'h0, 15'h7DFF);
      `CHK(o_run_summary, 1'b1)
      chk_rd(4'h1, 15'h7DFF);
      chk_rd(4'h1, 15'h0000);
      `CHK(o_run_summary, 1'b0)
      host_u.wr(4'h4, 15'h0208);
      host_u.wr(4'h3, 15'h0000);
      i_run_other = 15'h0000;
      i_sweeping = 1'b0;
      i_selftest_busy = 1'b1;
      chk_rd(4'h0, 15'h0200);
      chk_rd(4'h1, 15'h0008);
   endtask
   task automatic s_health;
      host_u.wr(4'h7, 15'h0020);
      i_lock_error = 1'b1;
      i_unleveled = 1'b1;
      i_selftest_failed = 1'b1;
      chk_rd(4'h5, 15'h0228);
      `CHK(o_health_summary, 1'b1)
      chk_rd(4'h6, 15'h0228);
      host_u.wr(4'h9, 15'h0008);
      i_unleveled = 1'b0;
      host_u.step();
      `CHK(o_health_summary, 1'b0)
      chk_rd(4'h6, 15'h0008);
   endtask
   task automatic s_queue;
      for (int n = 1; n <= 11; n++) push(n[15:0]);
      `CHK(o_err_count, 4'hA)
      `CHK(o_summary_byte, 8'h04)
      for (int n = 1; n <= 10; n++) begin
         host_u.pop(c);
         `CHK(c, (n == 10) ? 16'hFEA2 : n[15:0])
         `CHK(o_err_desc, (n == 10) ? 8'h01 : n[7:0])
      end
      `CHK(o_summary_byte, 8'h00)
      host_u.pop(c);
      `CHK(c, 16'h0000)
   endtask
   initial begin
      repeat (12) @(posedge i_clk_sys);
      #1;
      i_srst = 1'b0;
      defaults();
      chk_rd(4'hF, 15'h0000);
      s_run();
      host_u.wr(4'h8, 15'h0000);
      host_u.wr(4'h9, 15'h7FFF);
      host_u.preset();
      defaults();
      s_health();
      s_queue();
      stop_test();
   end
endmodule
bind srr_top srr_sva chk_u (.i_clk_sys, .i_srst, .i_reg_rd, .i_reg_wr, .i_reg_sel, .i_preset, .i_err_push,
   .i_err_pop, .o_reg_rvalid, .o_reg_rdata, .o_err_valid, .o_err_code, .o_err_count, .o_summary_byte);
`default_nettype wire
